// [hdl/bus_matrix_pkg.sv]
// Constants, types and register map of the bus matrix configuration block
// How it works
// - Shared bus unmapped access raises bus error only when its enable is set
// - Debug unit unmapped access raises bus error only when its enable is set
// - DMA unmapped access raises bus error only when its enable is set
// - CPU data unmapped access errors when enabled, never while in debug mode
// - CPU fetch unmapped access errors when enabled, never while in debug mode
// - Wait-state bit adds one setup cycle to CPU accesses of data RAM
// - Arbitration field codes 000, 001, 010 pick modes 0, 1, 2; 1 default
// - Reset sets all five error enables, wait state, and arbitration 001
// - Bits 31-21, 15-7 and 5-3 ignore writes and read as zero
package bus_matrix_pkg;

	localparam int N_INIT = 5;

	// Initiator indices; error enable bit is ERR_EN_LSB plus the index
	localparam int INIT_CPU_INSTR = 0;
	localparam int INIT_CPU_DATA = 1;
	localparam int INIT_DMA = 2;
	localparam int INIT_DEBUG = 3;
	localparam int INIT_SHARED = 4;

	// Register byte offsets
	localparam logic [11:0] OFF_CONFIG = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_MASK = 12'h008;
	localparam logic [11:0] OFF_ERR_ADDR = 12'h00C;

	// Configuration register layout
	localparam int ERR_EN_LSB = 16;
	localparam int BIT_ERR_CPU_INSTR = 16;
	localparam int BIT_ERR_CPU_DATA = 17;
	localparam int BIT_ERR_DMA = 18;
	localparam int BIT_ERR_DEBUG = 19;
	localparam int BIT_ERR_SHARED = 20;
	localparam int BIT_RAM_WAIT = 6;
	localparam int ARB_LSB = 0;
	localparam int ARB_W = 3;
	localparam logic [31:0] CONFIG_RESET = 32'h001F_0041;
	localparam logic [31:0] CONFIG_WMASK = 32'h001F_0047;

	// Arbitration codes
	localparam logic [2:0] ARB_CODE_MODE0 = 3'h0;
	localparam logic [2:0] ARB_CODE_MODE1 = 3'h1;
	localparam logic [2:0] ARB_CODE_MODE2 = 3'h2;

	// Status and mask: one bit per initiator, bit index equals initiator index
	localparam logic [N_INIT-1:0] STATUS_RESET = 5'h00;
	localparam logic [N_INIT-1:0] MASK_RESET = 5'h00;
	localparam logic [31:0] ERR_ADDR_RESET = 32'h0000_0000;

	// Address map of the targets
	localparam logic [31:0] RAM_BASE = 32'h0000_0000;
	localparam logic [31:0] RAM_SIZE = 32'h0000_8000;
	localparam logic [31:0] FLASH_BASE = 32'h1000_0000;
	localparam logic [31:0] FLASH_SIZE = 32'h0002_0000;
	localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
	localparam logic [31:0] PERIPH_SIZE = 32'h0010_0000;

	// Extra address setup cycles on CPU data RAM access
	localparam logic [1:0] RAM_WAIT_CYCLES = 2'h1;

	typedef enum logic [1:0] {
		TGT_RAM,
		TGT_FLASH,
		TGT_PERIPH,
		TGT_NONE
	} target_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
	} init_req_t;

	typedef struct packed {
		logic [2:0] initiator;
		logic write;
		logic [31:0] addr;
		target_t sel;
	} tgt_access_t;

endpackage

// [hdl/matrix_arbiter.sv]
// Arbiter that picks one of the requesting initiators by the selected mode
`timescale 1ns/10ps
`default_nettype none
module matrix_arbiter (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Requests and mode
	input wire logic [bus_matrix_pkg::N_INIT-1:0] req,
	input wire logic [2:0] mode,
	input wire logic take,
	// Grant
	output logic any,
	output logic [2:0] gnt
);
	logic [2:0] last;

	// Mode 0: lowest index wins; mode 2: highest index wins;
	// mode 1: round robin after the last winner. Reserved codes act as
	// mode 1 so the matrix never locks up on a bad setting.
	always_comb begin
		int idx;
		gnt = 3'h0;
		any = |req;
		idx = 0;
		unique case (mode)
			bus_matrix_pkg::ARB_CODE_MODE0: begin
				for (int i = bus_matrix_pkg::N_INIT - 1; i >= 0; i--) begin
					if (req[i]) gnt = 3'(i);
				end
			end
			bus_matrix_pkg::ARB_CODE_MODE2: begin
				for (int i = 0; i < bus_matrix_pkg::N_INIT; i++) begin
					if (req[i]) gnt = 3'(i);
				end
			end
			default: begin
				for (int k = bus_matrix_pkg::N_INIT; k >= 1; k--) begin
					idx = (int'(last) + k) % bus_matrix_pkg::N_INIT;
					if (req[idx]) gnt = 3'(idx);
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			last <= 3'(bus_matrix_pkg::N_INIT - 1);
		end else if (take && any) begin
			last <= gnt;
		end
	end
endmodule // matrix_arbiter
`default_nettype wire

// [hdl/bus_matrix_config.sv]
// Bus matrix: APB configuration, arbitration, decode and error reporting
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module bus_matrix_config (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Initiators
	input wire bus_matrix_pkg::init_req_t [bus_matrix_pkg::N_INIT-1:0] init_req,
	input wire logic cpu_debug_mode,
	output logic [bus_matrix_pkg::N_INIT-1:0] init_done,
	output logic [bus_matrix_pkg::N_INIT-1:0] init_bus_err,
	// Target side
	output bus_matrix_pkg::tgt_access_t tgt_access,
	output logic tgt_strobe,
	// Interrupt
	output logic irq
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SETUP,
		ST_ACCESS
	} state_t;

	state_t state;
	logic [31:0] bus_matrix_config;
	logic [bus_matrix_pkg::N_INIT-1:0] status;
	logic [bus_matrix_pkg::N_INIT-1:0] mask;
	logic [31:0] err_addr;
	// Decoded fields of the configuration word
	logic [bus_matrix_pkg::N_INIT-1:0] err_en_vec;
	logic err_en_shared_bus;
	logic err_en_debug_unit;
	logic err_en_dma;
	logic err_en_cpu_data;
	logic err_en_cpu_instr;
	logic ram_wait_state;
	logic [2:0] arb_mode_sel;

	logic [bus_matrix_pkg::N_INIT-1:0] req_vec;
	logic arb_any;
	logic [2:0] arb_gnt;
	logic [2:0] cur_init;
	logic cur_write;
	logic [31:0] cur_addr;
	bus_matrix_pkg::target_t cur_sel;
	bus_matrix_pkg::target_t next_sel;
	logic [1:0] wait_cnt;
	logic need_wait;
	logic report_err;
	logic [bus_matrix_pkg::N_INIT-1:0] err_event;

	logic apb_write;
	logic apb_read;
	logic addr_hit;

	// Per-register selects and strobes
	logic sel_config;
	logic sel_status;
	logic sel_mask;
	logic sel_err_addr;
	logic cfg_wr;
	logic mask_wr;
	logic status_clr;
	logic [31:0] cfg_view;

	// Field view of the configuration register
	assign err_en_cpu_instr = bus_matrix_config[bus_matrix_pkg::BIT_ERR_CPU_INSTR];
	assign err_en_cpu_data = bus_matrix_config[bus_matrix_pkg::BIT_ERR_CPU_DATA];
	assign err_en_dma = bus_matrix_config[bus_matrix_pkg::BIT_ERR_DMA];
	assign err_en_debug_unit = bus_matrix_config[bus_matrix_pkg::BIT_ERR_DEBUG];
	assign err_en_shared_bus = bus_matrix_config[bus_matrix_pkg::BIT_ERR_SHARED];
	assign ram_wait_state = bus_matrix_config[bus_matrix_pkg::BIT_RAM_WAIT];
	assign arb_mode_sel =
		bus_matrix_config[bus_matrix_pkg::ARB_LSB +: bus_matrix_pkg::ARB_W];

	// CPU enables drop out while the core is halted in debug
	always_comb begin
		err_en_vec = '0;
		err_en_vec[bus_matrix_pkg::INIT_CPU_INSTR] =
			err_en_cpu_instr & ~cpu_debug_mode;
		err_en_vec[bus_matrix_pkg::INIT_CPU_DATA] =
			err_en_cpu_data & ~cpu_debug_mode;
		err_en_vec[bus_matrix_pkg::INIT_DMA] = err_en_dma;
		err_en_vec[bus_matrix_pkg::INIT_DEBUG] = err_en_debug_unit;
		err_en_vec[bus_matrix_pkg::INIT_SHARED] = err_en_shared_bus;
	end

	// APB decode; zero wait states, pready always high
	assign pready = 1'b1;
	assign apb_write = psel & penable & pwrite;
	assign apb_read = psel & penable & ~pwrite;
	assign sel_config = paddr == bus_matrix_pkg::OFF_CONFIG;
	assign sel_status = paddr == bus_matrix_pkg::OFF_STATUS;
	assign sel_mask = paddr == bus_matrix_pkg::OFF_MASK;
	assign sel_err_addr = paddr == bus_matrix_pkg::OFF_ERR_ADDR;
	assign addr_hit = sel_config | sel_status | sel_mask | sel_err_addr;
	assign pslverr = psel & penable & ~addr_hit;

	// Error address is read-only, so it has no write strobe
	assign cfg_wr = apb_write & sel_config;
	assign mask_wr = apb_write & sel_mask;
	assign status_clr = apb_write & sel_status;

	// Read image rebuilt from the fields so unused bits cannot leak
	assign cfg_view = {11'h000, err_en_shared_bus, err_en_debug_unit,
		err_en_dma, err_en_cpu_data, err_en_cpu_instr, 9'h000,
		ram_wait_state, 3'h0, arb_mode_sel};

	always_comb begin
		prdata = 32'h0000_0000;
		if (apb_read) begin
			unique case (paddr)
				bus_matrix_pkg::OFF_CONFIG: prdata = cfg_view;
				bus_matrix_pkg::OFF_STATUS: prdata = {27'h0, status};
				bus_matrix_pkg::OFF_MASK: prdata = {27'h0, mask};
				bus_matrix_pkg::OFF_ERR_ADDR: prdata = err_addr;
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// Only implemented bits store; the rest stay zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bus_matrix_config <= bus_matrix_pkg::CONFIG_RESET;
		end else if (cfg_wr) begin
			bus_matrix_config <= pwdata & bus_matrix_pkg::CONFIG_WMASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			mask <= bus_matrix_pkg::MASK_RESET;
		end else if (mask_wr) begin
			mask <= pwdata[bus_matrix_pkg::N_INIT-1:0];
		end
	end

	// Write one to clear; a new error in the same cycle wins
	always_ff @(posedge clk) begin
		if (!rstn) begin
			status <= bus_matrix_pkg::STATUS_RESET;
		end else begin
			if (status_clr) begin
				status <= (status & ~pwdata[bus_matrix_pkg::N_INIT-1:0])
					| err_event;
			end else begin
				status <= status | err_event;
			end
		end
	end

	assign irq = |(status & mask);

	// Arbitration; an initiator just answered is held off one cycle
	// because it still shows its old request while it sees done
	always_comb begin
		for (int i = 0; i < bus_matrix_pkg::N_INIT; i++) begin
			req_vec[i] = init_req[i].valid & ~init_done[i];
		end
	end

	matrix_arbiter arb (
		.clk(clk),
		.rstn(rstn),
		.req(req_vec),
		.mode(arb_mode_sel),
		.take(state == ST_IDLE),
		.any(arb_any),
		.gnt(arb_gnt)
	);

	// Address decode of the granted request
	always_comb begin
		logic [31:0] a;
		a = init_req[arb_gnt].addr;
		next_sel = bus_matrix_pkg::TGT_NONE;
		if (a - bus_matrix_pkg::RAM_BASE < bus_matrix_pkg::RAM_SIZE) begin
			next_sel = bus_matrix_pkg::TGT_RAM;
		end else if (a - bus_matrix_pkg::FLASH_BASE <
			bus_matrix_pkg::FLASH_SIZE) begin
			next_sel = bus_matrix_pkg::TGT_FLASH;
		end else if (a - bus_matrix_pkg::PERIPH_BASE <
			bus_matrix_pkg::PERIPH_SIZE) begin
			next_sel = bus_matrix_pkg::TGT_PERIPH;
		end
	end

	// Only CPU ports pay the RAM setup cycle
	assign need_wait = ram_wait_state &&
		next_sel == bus_matrix_pkg::TGT_RAM &&
		(arb_gnt == 3'(bus_matrix_pkg::INIT_CPU_INSTR) ||
		arb_gnt == 3'(bus_matrix_pkg::INIT_CPU_DATA));

	// Sequencer: optional RAM setup cycle, then one access cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= ST_IDLE;
			wait_cnt <= 2'h0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (arb_any) begin
						if (need_wait) begin
							state <= ST_SETUP;
							wait_cnt <= bus_matrix_pkg::RAM_WAIT_CYCLES;
						end else begin
							state <= ST_ACCESS;
						end
					end
				end
				ST_SETUP: begin
					wait_cnt <= wait_cnt - 2'h1;
					if (wait_cnt == 2'h1) state <= ST_ACCESS;
				end
				ST_ACCESS: begin
					state <= ST_IDLE;
				end
				// Unused state code falls back to idle
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Latch the granted request; held until the access cycle ends
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cur_init <= 3'h0;
			cur_write <= 1'b0;
			cur_addr <= 32'h0000_0000;
			cur_sel <= bus_matrix_pkg::TGT_NONE;
		end else if (state == ST_IDLE && arb_any) begin
			cur_init <= arb_gnt;
			cur_write <= init_req[arb_gnt].write;
			cur_addr <= init_req[arb_gnt].addr;
			cur_sel <= next_sel;
		end
	end

	// Enable sampled at the access cycle so a debug entry mid-wait counts
	assign report_err = cur_sel == bus_matrix_pkg::TGT_NONE &&
		err_en_vec[cur_init];
	always_comb begin
		err_event = '0;
		if (state == ST_ACCESS && report_err) begin
			err_event[cur_init] = 1'b1;
		end
	end

	// Every granted access ends with done, mapped or not; error only
	// when the initiator's enable lets it through
	always_ff @(posedge clk) begin
		if (!rstn) begin
			init_done <= '0;
			init_bus_err <= '0;
		end else begin
			init_done <= '0;
			init_bus_err <= '0;
			if (state == ST_ACCESS) begin
				init_done[cur_init] <= 1'b1;
				init_bus_err <= err_event;
			end
		end
	end

	// Unmapped accesses never reach a target
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tgt_strobe <= 1'b0;
			tgt_access <= '{3'h0, 1'b0, 32'h0000_0000,
				bus_matrix_pkg::TGT_NONE};
		end else begin
			tgt_strobe <= state == ST_ACCESS &&
				cur_sel != bus_matrix_pkg::TGT_NONE;
			if (state == ST_ACCESS) begin
				tgt_access <= '{cur_init, cur_write, cur_addr, cur_sel};
			end
		end
	end

	// Last reported error address, for software triage
	always_ff @(posedge clk) begin
		if (!rstn) begin
			err_addr <= bus_matrix_pkg::ERR_ADDR_RESET;
		end else if (|err_event) begin
			err_addr <= cur_addr;
		end
	end
endmodule // bus_matrix_config
`default_nettype wire

// [dv/bus_matrix_props.sv]
// Concurrent checks on the bus matrix ports
`timescale 1ns/10ps
`default_nettype none
module bus_matrix_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Initiators and target side
	input wire bus_matrix_pkg::init_req_t [4:0] init_req,
	input wire logic cpu_debug_mode,
	input wire logic [4:0] init_done,
	input wire logic [4:0] init_bus_err,
	input wire bus_matrix_pkg::tgt_access_t tgt_access,
	input wire logic tgt_strobe
);
	logic [31:0] cfg;
	logic acc;
	assign acc = psel && penable;
	// Shadow of the config word, taken as the slave takes it
	always_ff @(posedge clk) begin
		if (!rstn)
			cfg <= bus_matrix_pkg::CONFIG_RESET;
		else if (acc && pwrite && paddr == 12'h000)
			cfg <= pwdata & bus_matrix_pkg::CONFIG_WMASK;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Enable and debug mode are those of the access cycle
	property p_err(int i);
		init_done[i] && tgt_access.sel == bus_matrix_pkg::TGT_NONE |->
			init_bus_err[i] == ($past(cfg[16 + i]) &&
			!(i < 2 && $past(cpu_debug_mode)));
	endproperty
	sequence s_dma_req;
		$rose(init_req[2].valid);
	endsequence
	sequence s_dma_done;
		##[2:30] init_done[2];
	endsequence
	AST_ERR_INSTR: assert property (p_err(0))
		else $error("fetch error report wrong");
	AST_ERR_DATA: assert property (p_err(1))
		else $error("data error report wrong");
	AST_ERR_DMA: assert property (p_err(2))
		else $error("dma error report wrong");
	AST_ERR_DEBUG: assert property (p_err(3))
		else $error("debug error report wrong");
	AST_ERR_SHARED: assert property (p_err(4))
		else $error("shared bus error report wrong");
	AST_ERR_ONLY_DONE: assert property (
		(init_bus_err & ~init_done) == 5'h00) else $error("error without done");
	AST_ERR_UNMAPPED: assert property (
		|init_bus_err |-> !tgt_strobe &&
		tgt_access.sel == bus_matrix_pkg::TGT_NONE)
		else $error("error on mapped access");
	AST_CFG_READ: assert property (
		acc && !pwrite && paddr == 12'h000 |-> prdata == cfg)
		else $error("config read wrong");
	AST_DMA_DONE: assert property (s_dma_req |-> s_dma_done)
		else $error("dma access never finished");
endmodule // bus_matrix_props
bind bus_matrix_config bus_matrix_props u_props (.clk, .rstn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .init_req, .cpu_debug_mode,
	.init_done, .init_bus_err, .tgt_access, .tgt_strobe);
`default_nettype wire

// [dv/init_model.sv]
// Initiator model: holds each request until the matrix finishes it
`timescale 1ns/10ps
`default_nettype none
module init_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bench commands
	input wire logic [4:0] go,
	input wire logic [31:0] a,
	// Matrix side
	input wire logic [4:0] done,
	output bus_matrix_pkg::init_req_t [4:0] req
);
	always_ff @(posedge clk) begin
		for (int i = 0; i < 5; i++) begin
			if (!rstn) begin
				req[i] <= '0;
			end else if (go[i]) begin
				req[i] <= '{1'b1, 1'b0, a};
			end else if (done[i]) begin
				// Released address must not look still held
				req[i].valid <= 1'b0;
				req[i].addr <= ~req[i].addr;
			end
		end
	end
endmodule // init_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the bus matrix configuration block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	bus_matrix_pkg::init_req_t [4:0] init_req;
	logic cpu_debug_mode = 1'b0;
	logic [4:0] init_done;
	logic [4:0] init_bus_err;
	bus_matrix_pkg::tgt_access_t tgt_access;
	logic tgt_strobe;
	logic irq;
	logic [4:0] go = 5'h00;
	logic [4:0] busy;
	logic [31:0] ia = 32'h0;
	logic [31:0] q;
	logic slv;
	logic [4:0] d;
	logic [4:0] e;
	logic ts;
	bus_matrix_pkg::tgt_access_t ta;
	int lat;
	int n_errors = 0;
	int comparisons = 0;
	localparam logic [31:0] CR = bus_matrix_pkg::CONFIG_RESET;
	localparam logic [31:0] BAD = 32'h2000_0000;
	localparam logic [31:0] RAM = 32'h0000_0100;
	always_comb
		for (int i = 0; i < 5; i++)
			busy[i] = init_req[i].valid;
	bus_matrix_config u_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .init_req, .cpu_debug_mode,
		.init_done, .init_bus_err, .tgt_access, .tgt_strobe, .irq);
	init_model u_init (.clk, .rstn, .go, .a(ia), .done(init_done),
		.req(init_req));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic conclude;
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] v);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		slv = pslverr;
		chk(32'(pready), 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic acc(input logic [4:0] g, input logic [31:0] a);
		go <= g;
		ia <= a;
		@(posedge clk);
		go <= 5'h00;
		lat = 1;
		while (init_done === 5'h00 && lat < 40) begin
			@(posedge clk);
			lat++;
		end
		d = init_done;
		e = init_bus_err;
		ts = tgt_strobe;
		ta = tgt_access;
		// Drain any loser of an arbitration before the next request
		while (busy !== 5'h00) begin
			@(posedge clk);
		end
	endtask
	task automatic t_regs;
		apb(1'b0, 12'h000, 32'h0);
		chk(q, CR);
		apb(1'b1, 12'h000, 32'hFFFF_FFFA);
		apb(1'b0, 12'h000, 32'h0);
		chk(q, bus_matrix_pkg::CONFIG_WMASK & 32'hFFFF_FFFA);
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, 12'h000, (CR & 32'hFFFF_FFF8) | 32'(c));
			apb(1'b0, 12'h000, 32'h0);
			chk(q, (CR & 32'hFFFF_FFF8) | 32'(c));
		end
		apb(1'b0, 12'h010, 32'h0);
		chk(32'(slv), 32'h1);
		apb(1'b1, 12'h000, CR);
	endtask
	task automatic t_err;
		logic [31:0] m;
		apb(1'b1, 12'h008, 32'h0000_001F);
		for (int i = 0; i < 5; i++)
			for (int en = 0; en < 2; en++) begin
				m = 32'h1 << (16 + i);
				apb(1'b1, 12'h000, en ? CR : CR & ~m);
				acc(5'h01 << i, BAD);
				chk(32'(d), 32'h1 << i);
				chk(32'(ts), 32'h0);
				chk(32'(e), 32'(en) << i);
				chk(32'(irq), 32'(en));
				apb(1'b0, 12'h004, 32'h0);
				chk(q, 32'(en) << i);
				apb(1'b1, 12'h004, q);
				chk(32'(irq), 32'h0);
			end
	endtask
	task automatic t_debug;
		cpu_debug_mode <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			acc(5'h01 << i, BAD);
			chk(32'(e), i == 2 ? 32'h4 : 32'h0);
		end
		cpu_debug_mode <= 1'b0;
		apb(1'b1, 12'h004, 32'h0000_001F);
	endtask
	task automatic t_wait;
		int base;
		acc(5'h04, RAM);
		base = lat;
		chk(32'(base), 32'h4);
		chk(32'(ts), 32'h1);
		chk(ta.addr, RAM);
		chk(32'(ta.initiator), 32'h2);
		acc(5'h02, RAM);
		chk(32'(lat), 32'(base + 1));
		acc(5'h01, RAM);
		chk(32'(lat), 32'(base + 1));
		apb(1'b1, 12'h000, CR & 32'hFFFF_FFBF);
		acc(5'h02, RAM);
		chk(32'(lat), 32'(base));
	endtask
	task automatic t_arb;
		apb(1'b1, 12'h000, CR & 32'hFFFF_FFF8);
		acc(5'h0C, RAM);
		chk(32'(d), 32'h4);
		apb(1'b1, 12'h000, (CR & 32'hFFFF_FFF8) | 32'h2);
		acc(5'h0C, RAM);
		chk(32'(d), 32'h8);
		apb(1'b1, 12'h000, CR);
		// Round robin resumes after the last winner, the DMA
		acc(5'h14, RAM);
		chk(32'(d), 32'h10);
		acc(5'h05, RAM);
		chk(32'(d), 32'h1);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_err();
		t_debug();
		t_wait();
		t_arb();
		conclude();
	end
	initial begin
		#400000;
		n_errors++;
		conclude();
	end
endmodule // testbench
`default_nettype wire
